// ===== logic/lpt_pkg.sv
package lpt_pkg;
  // register byte offsets
  localparam logic [7:0] LPT_OFS_STATUS = 8'h00;
  localparam logic [7:0] LPT_OFS_CLEAR = 8'h04;
  localparam logic [7:0] LPT_OFS_IRQ_EN = 8'h08;
  localparam logic [7:0] LPT_OFS_CONFIG = 8'h0C;
  localparam logic [7:0] LPT_OFS_RELOAD = 8'h18;
  localparam logic [7:0] LPT_OFS_COUNT = 8'h1C;
  // field positions
  localparam int LPT_BIT_MATCH = 1;
  localparam int LPT_BIT_DEFER = 22;
  localparam int LPT_DIV_LSB = 9;
  localparam int LPT_DIV_MSB = 11;
  // widths and reset values
  localparam int LPT_CNT_W = 16;
  localparam int LPT_DIV_W = 3;
  localparam logic [15:0] LPT_RELOAD_RST = 16'h0001;
  localparam logic [15:0] LPT_CNT_RST = 16'h0000;
  localparam logic [6:0] LPT_PRE_RST = 7'h00;
  localparam logic [31:0] LPT_ZERO = 32'h0000_0000;

  // one bus request as seen in the access phase
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } lpt_bus_req_t;

  // configuration handed to the counting engine
  typedef struct packed {
    logic run;
    logic [2:0] div_sel;
    logic [15:0] reload;
  } lpt_core_cfg_t;
endpackage : lpt_pkg

// ===== logic/lpt_core.sv
`timescale 1ns/1ps
module lpt_core
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // configuration
  input wire lpt_pkg::lpt_core_cfg_t cfg,
  // events and state
  output logic match_pulse,
  output logic [15:0] count
);
  import lpt_pkg::*;

  logic [6:0] pre;
  logic [6:0] pre_mask;
  logic tick;
  logic hit;

  // prescaler wraps at 2^div_sel, tick every wrap
  assign pre_mask = 7'((8'h01 << cfg.div_sel) - 8'h01);
  assign tick = cfg.run && ((pre & pre_mask) == pre_mask);
  assign hit = tick && (count == cfg.reload);

  // prescaler and counter, counter wraps at reload
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !cfg.run)
    begin
      pre <= LPT_PRE_RST;
      count <= LPT_CNT_RST;
      match_pulse <= 1'b0;
    end
    else
    begin
      pre <= tick ? LPT_PRE_RST : 7'(pre + 7'h01);
      count <= hit ? LPT_CNT_RST : (tick ? 16'(count + 16'h0001) : count);
      match_pulse <= hit;
    end
  end
endmodule : lpt_core

// ===== logic/lpt_regs.sv
// Behaviour
// - counter equal reload sets read-only match flag
// - write one to clear bit clears flag
// - enable bit gates the match interrupt
// - deferred bit zero: reload written immediately
// - deferred bit one: reload applied at period end while running
// - divider select divides counting clock by 2^n
// - config and enable writable only while disabled
// - enabling after flag set raises no interrupt
// - written values reach comparator on the write edge, deferred reload at period end
`timescale 1ns/1ps
module lpt_regs
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // peripheral bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer core enable from the control register
  input wire logic timer_enable,
  // interrupt and counting state
  output logic timer_irq_out,
  output logic [15:0] counter_value_reg,
  output logic [2:0] clock_divider_select
);
  import lpt_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic reload_match_flag;
  logic reload_match_irq_enable;
  logic irq_armed;
  logic defer_update;
  logic [15:0] reload_value_reg;
  logic [15:0] reload_active;
  logic reload_pending;
  logic match_pulse;
  logic [15:0] count;
  lpt_bus_req_t req;
  lpt_core_cfg_t core_cfg;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic setup_phase;
  logic wr_access;
  logic wr_clear;
  logic wr_irq_en;
  logic wr_config;
  logic wr_reload;
  logic addr_ok;
  logic clear_hit;
  logic next_flag;
  logic next_irq_en;
  logic next_armed;
  logic [31:0] next_rdata;

  // bundle bus inputs, decode writes in the access phase
  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  assign setup_phase = req.sel && !req.enable;
  assign wr_access = req.sel && req.enable && req.write && pready && !pslverr;
  assign wr_clear = wr_access && (req.addr == LPT_OFS_CLEAR);
  assign wr_irq_en = wr_access && (req.addr == LPT_OFS_IRQ_EN) && !timer_enable;
  assign wr_config = wr_access && (req.addr == LPT_OFS_CONFIG) && !timer_enable;
  assign wr_reload = wr_access && (req.addr == LPT_OFS_RELOAD);
  assign addr_ok = (req.addr == LPT_OFS_STATUS) || (req.addr == LPT_OFS_CLEAR)
    || (req.addr == LPT_OFS_IRQ_EN) || (req.addr == LPT_OFS_CONFIG)
    || (req.addr == LPT_OFS_RELOAD) || (req.addr == LPT_OFS_COUNT);

  // read mux, reserved bits read zero
  always_comb
  begin
    next_rdata = LPT_ZERO;
    if (req.addr == LPT_OFS_STATUS)
      next_rdata[LPT_BIT_MATCH] = reload_match_flag;
    else if (req.addr == LPT_OFS_IRQ_EN)
      next_rdata[LPT_BIT_MATCH] = reload_match_irq_enable;
    else if (req.addr == LPT_OFS_CONFIG)
    begin
      next_rdata[LPT_BIT_DEFER] = defer_update;
      next_rdata[LPT_DIV_MSB:LPT_DIV_LSB] = clock_divider_select;
    end
    else if (req.addr == LPT_OFS_RELOAD)
      next_rdata[LPT_CNT_W-1:0] = reload_value_reg;
    else if (req.addr == LPT_OFS_COUNT)
      next_rdata[LPT_CNT_W-1:0] = count;
  end

  // answer prepared in setup phase, one wait-free access phase
  // read data only for reads, a write access shows zero
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= LPT_ZERO;
    end
    else
    begin
      pready <= setup_phase;
      pslverr <= setup_phase && !addr_ok;
      prdata <= (setup_phase && !req.write) ? next_rdata : LPT_ZERO;
    end
  end

  // ----------------------------------------
  // match flag and interrupt
  // ----------------------------------------
  // set wins over a same-cycle clear
  assign clear_hit = wr_clear && req.wdata[LPT_BIT_MATCH];
  assign next_flag = match_pulse || (reload_match_flag && !clear_hit);
  // enable acts in the cycle of its write, so masking drops the line at once
  assign next_irq_en = wr_irq_en ? req.wdata[LPT_BIT_MATCH] : reload_match_irq_enable;
  // only a match seen while enabled arms the line
  assign next_armed = next_irq_en && next_flag && (match_pulse || irq_armed);

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      reload_match_flag <= 1'b0;
      irq_armed <= 1'b0;
      timer_irq_out <= 1'b0;
    end
    else
    begin
      reload_match_flag <= next_flag;
      irq_armed <= next_armed;
      timer_irq_out <= next_armed;
    end
  end

  // ----------------------------------------
  // enable and configuration
  // ----------------------------------------
  // low config bits are never stored, they read back zero
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      reload_match_irq_enable <= 1'b0;
      defer_update <= 1'b0;
      clock_divider_select <= 3'h0;
    end
    else
    begin
      if (wr_irq_en)
        reload_match_irq_enable <= req.wdata[LPT_BIT_MATCH];
      if (wr_config)
      begin
        defer_update <= req.wdata[LPT_BIT_DEFER];
        clock_divider_select <= req.wdata[LPT_DIV_MSB:LPT_DIV_LSB];
      end
    end
  end

  // ----------------------------------------
  // reload update
  // ----------------------------------------
  // comparator copy takes the written value in the same cycle, or at period end when deferred while running
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      reload_value_reg <= LPT_RELOAD_RST;
      reload_active <= LPT_RELOAD_RST;
      reload_pending <= 1'b0;
    end
    else
    begin
      if (wr_reload)
        reload_value_reg <= req.wdata[LPT_CNT_W-1:0];
      if (wr_reload && (!defer_update || !timer_enable))
      begin
        reload_active <= req.wdata[LPT_CNT_W-1:0];
        reload_pending <= 1'b0;
      end
      else if (wr_reload)
        reload_pending <= 1'b1;
      else if (reload_pending && (match_pulse || !timer_enable))
      begin
        reload_active <= reload_value_reg;
        reload_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // counting engine
  // ----------------------------------------
  // run, divider and active reload bundled for the counting engine
  assign core_cfg = '{run: timer_enable, div_sel: clock_divider_select, reload: reload_active};

  lpt_core u_core
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .cfg(core_cfg),
    .match_pulse(match_pulse),
    .count(count)
  );

  // registered copy of the count for the output port
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      counter_value_reg <= LPT_CNT_RST;
    else
      counter_value_reg <= count;
  end
endmodule : lpt_regs

// ===== dv/lpt_regs_asserts.sv
`timescale 1ns/1ps
module lpt_chk
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // peripheral bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // timer side
  input wire logic timer_enable,
  input wire logic timer_irq_out,
  input wire logic [15:0] counter_value_reg,
  input wire logic [2:0] clock_divider_select
);
  import lpt_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // access-phase decodes
  wire wr = pready && pwrite && !timer_enable;
  wire hit = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h1C};
  // --------------------------------
  // checks
  // --------------------------------
  a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready");
  a_err_unmapped: assert property (pready |-> pslverr == !hit) else $error("bad error");
  a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0) else $error("rdata");
  a_div_write:
    assert property (wr && paddr == 8'h0C |=> clock_divider_select == $past(pwdata[11:9]))
    else $error("divider not written");
  a_cfg_locked:
    assert property (pready && pwrite && timer_enable && paddr == 8'h0C
      |=> $stable(clock_divider_select)) else $error("config written while running");
  a_clear_irq:
    assert property (wr && paddr == 8'h04 && pwdata[1] |=> !timer_irq_out) else $error("clr");
  a_mask_irq:
    assert property (wr && paddr == 8'h08 && !pwdata[1] |=> !timer_irq_out) else $error("mask");
  a_flag_read:
    assert property (pready && !pwrite && paddr == 8'h00 && timer_irq_out |-> prdata[1])
    else $error("flag not read");
  a_irq_source:
    assert property ($rose(timer_irq_out) |-> $past(timer_enable, 2)) else $error("late irq");
  // main scenarios
  cover property (pready && pslverr);
  cover property ($rose(timer_irq_out));
  cover property (wr && paddr == 8'h0C);
endmodule : lpt_chk

// ===== dv/lpt_regs_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module lpt_regs_bench;
  import lpt_pkg::*;
  logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, timer_enable = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, timer_irq_out, e;
  logic [15:0] counter_value_reg, mx;
  logic [2:0] clock_divider_select;
  int mismatches = 0, checked = 0, seed = 32'h4b101d97, n;
  always #4 mclk = ~mclk;
  lpt_regs u_lpt_regs (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer_enable, .timer_irq_out, .counter_value_reg, .clock_divider_select);
  // one bus transfer, result taken in the access phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    {psel, pwrite, paddr, pwdata} = {1'b1, w, a, d};
    @(negedge mclk);
    penable = 1;
    q = prdata;
    e = pslverr;
    `CHK(pready, 1'b1)
    @(negedge mclk);
    {psel, penable} = 2'b00;
  endtask : bus
  // expected clocks between count steps for a divider code
  function automatic int exp_ticks(input logic [2:0] sel);
    return 1 << sel;
  endfunction : exp_ticks
  // expected peak count: deferred keeps the first reload for the period
  function automatic logic [15:0] exp_peak(input logic df, input logic [15:0] r2);
    return df ? 16'h000C : r2;
  endfunction : exp_peak
  // one period with a reload rewritten mid-run
  task automatic per(input logic df, input logic [15:0] r2);
    bus(1, 8'h0C, {9'h0, df, 10'h0, 3'h2, 9'h0});
    bus(1, 8'h18, 32'h0000000C);
    @(negedge mclk) timer_enable = 1;
    for (n = 0; n < 200 && counter_value_reg !== 16'h0001; n++) @(negedge mclk);
    bus(1, 8'h18, {16'h0, r2});
    mx = 16'h0;
    for (n = 0; n < 400 && counter_value_reg !== 16'h0; n++)
      @(negedge mclk) mx = (counter_value_reg > mx) ? counter_value_reg : mx;
    `CHK(mx, exp_peak(df, r2))
    repeat (12) @(negedge mclk);
    `CHK(timer_irq_out, 1'b1)
    timer_enable = 0;
    bus(1, 8'h04, 32'h0);
    bus(0, 8'h00, 32'h0);
    `CHK(q[1], 1'b1)
    bus(1, 8'h08, 32'h0);
    `CHK(timer_irq_out, 1'b0)
    bus(1, 8'h08, 32'h2);
    `CHK(timer_irq_out, 1'b0)
    bus(1, 8'h04, 32'h2);
    `CHK(timer_irq_out, 1'b0)
    bus(0, 8'h00, 32'h0);
    `CHK(q[1], 1'b0)
  endtask : per
  task final_report;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  // watchdog
  initial
  begin
    #400000;
    mismatches++;
    final_report();
  end
  initial
  begin
    repeat (12) @(negedge mclk);
    reset_n = 1;
    for (int i = 0; i < 4; i++)
    begin
      bus(0, 8'(i * 4), 32'h0);
      `CHK(q, 32'h0)
    end
    bus(0, 8'h18, 32'h0);
    `CHK(q, 32'h1)
    bus(0, 8'h10, 32'h0);
    `CHK(e, 1'b1)
    bus(1, 8'h08, 32'h2);
    per(0, 16'h0005);
    per(1, 16'h0005);
    bus(1, 8'h08, 32'h0);
    @(negedge mclk) timer_enable = 1;
    repeat (80) @(negedge mclk);
    timer_enable = 0;
    bus(1, 8'h08, 32'h2);
    repeat (3) @(negedge mclk);
    `CHK(timer_irq_out, 1'b0)
    bus(0, 8'h00, 32'h0);
    `CHK(q[1], 1'b1)
    timer_enable = 1;
    bus(1, 8'h0C, 32'h00000A00);
    `CHK(clock_divider_select, 3'h2)
    timer_enable = 0;
    for (int d = 0; d < 8; d++)
    begin
      bus(1, 8'h0C, {20'h0, d[2:0], 9'h0});
      `CHK(clock_divider_select, d[2:0])
      bus(1, 8'h18, {16'h0, 16'h0003 + 16'($random(seed) & 7)});
      @(negedge mclk) timer_enable = 1;
      for (int k = 0; k < 2; k++)
      begin
        mx = counter_value_reg;
        for (n = 0; n < 300 && counter_value_reg === mx; n++) @(negedge mclk);
      end
      `CHK(n, exp_ticks(d[2:0]))
      timer_enable = 0;
    end
    final_report();
  end
endmodule : lpt_regs_bench
bind lpt_regs lpt_chk u_lpt_chk (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .timer_enable, .timer_irq_out, .counter_value_reg,
  .clock_divider_select);
